/* File: bench/zero_seq_recloser_tb.sv */
// testbench: zero-sequence recloser against a protection and breaker model
`timescale 1ns/1ps
module zero_seq_recloser_tb
    import zsr_pkg::*;
;
    localparam int TK = 4;
    logic clk = 1'b0, rstn = 1'b0, en = 1'b0, fault = 1'b0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [3:0] lag = 4'h0, ws = 4'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdo, rdat;
    logic trip, blk, rb, ra, cl, ob, irq, awr, wrd, bv, arr, rv;
    logic [1:0] bresp, rresp, rsp;
    logic [15:0] seed = 16'h4004;
    logic [2:0] dly [8];
    int failures = 0, checked = 0, cyc = 0, n;

    always #5 clk = ~clk;

    zero_seq_recloser #(.TICK_CYCLES(TK), .MS_CYCLES(4)) DUT (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .CE_I(1'b1), .ENABLE_I(en), .OVERVOLTAGE_TRIP_IN_I(trip), .OVERVOLTAGE_BLOCKED_IN_I(blk),
        .RECLOSER_BLOCKED_O(rb), .RECLOSER_ACTIVE_O(ra), .BREAKER_CLOSE_CMD_O(cl),
        .OVERVOLTAGE_BLOCK_OUT_O(ob), .IRQ_O(irq), .AWVALID_I(awv), .AWREADY_O(awr),
        .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(ws),
        .BVALID_O(bv), .BREADY_I(br), .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr),
        .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rdo), .RRESP_O(rresp));
    zsr_feeder_model M (.clk_i(clk), .rstn_i(rstn), .fault_i(fault), .lag_i(lag),
        .close_i(cl), .block_i(ob), .trip_o(trip), .blocked_o(blk));

    // ========================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [2:0] fcond(input logic [2:0] f);
        case (f)
            FORCE_BLOCK: return COND_BLOCKED;
            FORCE_REQUESTED: return COND_REQUESTED;
            FORCE_CLOSE_CMD: return COND_CLOSE_CMD;
            default: return COND_CLOSED_BLK;
        endcase
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // trailing edge: the next call never re-drives a strobe in the same time step
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aok = 1'b0, wok = 1'b0;
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(aok && wok)) begin
            @(posedge clk);
            if (awv && awr) begin
                aok = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wrd) begin
                wok = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        chk("bresp", 32'(er), 32'(bresp));
        br <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rdat = rdo;
        rsp = rresp;
        rr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input string s, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        axr(a);
        chk(s, e, rdat & m);
    endtask
    task automatic run(input int g, input int d);
        axw(CTRL_ADDR, 32'(g) << 4, RESP_OKAY);
        fault <= 1'b1;
        while (ob !== 1'b1) @(posedge clk);
        n = 0;
        while (cl !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("close delay", 1, 32'(n >= (d - 1) * TK && n <= (d + 1) * TK));
        @(posedge clk);
        chk("close pulse", 0, {31'h0, cl});
        repeat (10) @(posedge clk);
        chk("held", 3, {30'h0, ra, ob});
        fault <= 1'b0;
        repeat (12) @(posedge clk);
        chk("cleared", 0, {30'h0, ra, ob});
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end

    // ========================================
    // scenarios
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rc("cond", COND_ADDR, 32'h7, 32'(COND_BLOCKED));
        rc("evt sel", EVT_SEL_ADDR, 32'h3ff, 32'(EVT_SEL_RESET));
        rc("delay", DELAY_BASE_ADDR, 32'h7ffff, 0);
        axr(8'h30);
        chk("bad read", 32'(RESP_DECERR), 32'(rsp));
        en <= 1'b1;
        repeat (8) @(posedge clk);
        rc("cond", COND_ADDR, 32'h7, 32'(COND_NORMAL));
        for (int g = 0; g < 8; g++) begin
            seed = lfsr(seed);
            dly[g] = (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0];
            axw(DELAY_BASE_ADDR + 8'(4 * g), 32'(dly[g]), RESP_OKAY);
            rc("delay", DELAY_BASE_ADDR + 8'(4 * g), 32'h7ffff, 32'(dly[g]));
        end
        axw(EVT_EN_ADDR, 32'h40, RESP_OKAY);
        axw(EVT_SEL_ADDR, 32'h37f, RESP_OKAY);
        lag <= seed[11:8];
        run(int'(seed[6:4]), int'(dly[seed[6:4]]));
        chk("irq", 1, {31'h0, irq});
        rc("evt stat", EVT_STAT_ADDR, 32'hc0, 32'h40);
        axw(EVT_CLR_ADDR, 32'h40, RESP_OKAY);
        chk("irq clear", 0, {31'h0, irq});
        axw(EVT_EN_ADDR, 0, RESP_OKAY);
        run(7, int'(dly[7]));
        chk("irq masked", 0, {31'h0, irq});
        rc("log info", LOG_INFO_ADDR, 32'hff, 32'h22);
        axw(LOG_SEL_ADDR, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        rc("log rec", LOG_REC_ADDR, 32'hffffff, 32'h80000f | (32'(dly[7]) << 4));
        axr(LOG_TS_ADDR);
        n = int'(rdat);
        axr(TIME_ADDR);
        chk("log stamp", 1, 32'(n > 0 && n < int'(rdat)));
        axw(DELAY_BASE_ADDR + 8'h1c, 32'h7, RESP_OKAY);
        fault <= 1'b1;
        while (ob !== 1'b1) @(posedge clk);
        repeat (TK) @(posedge clk);
        fault <= 1'b0;
        n = 0;
        repeat (60) @(posedge clk) n += int'(cl);
        chk("no close", 0, 32'(n));
        for (int f = 1; f < 5; f++) begin
            axw(CTRL_ADDR, 32'h71 | 32'(f << 1), RESP_OKAY);
            repeat (3) @(posedge clk);
            rc("forced", COND_ADDR, 32'h7, 32'(fcond(3'(f))));
            chk("forced blk", 32'(f == 1), {31'h0, rb});
        end
        rc("group", CTRL_ADDR, 32'h70, 32'h70);
        axw(CTRL_ADDR, 32'h70, RESP_OKAY);
        en <= 1'b0;
        repeat (8) @(posedge clk);
        rc("cond", COND_ADDR, 32'h7, 32'(COND_BLOCKED));
        summarize();
    end
endmodule  // zero_seq_recloser_tb

/* File: bench/zsr_feeder_model.sv */
// partner model: overvoltage protection and feeder breaker facing the recloser
`timescale 1ns/1ps
module zsr_feeder_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // bench controls: fault present, lag before the blocked indication
    input wire logic fault_i,
    input wire logic [3:0] lag_i,
    // recloser side
    input wire logic close_i,
    input wire logic block_i,
    output logic trip_o,
    output logic blocked_o
);
    // ========================================
    // protection and breaker
    logic closed;
    logic [3:0] open_cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            closed <= 1'b1;
            open_cnt <= 4'h0;
            trip_o <= 1'b0;
            blocked_o <= 1'b0;
        end else begin
            if (close_i)
                closed <= 1'b1;
            else if (trip_o)
                closed <= 1'b0;
            open_cnt <= closed ? 4'h0 : open_cnt + 4'(open_cnt != lag_i);
            // trip held until blocked is up, else the recloser drops back to normal
            trip_o <= fault_i && !block_i && !blocked_o;
            blocked_o <= fault_i && (block_i || (!closed && open_cnt == lag_i));
        end
    end
endmodule  // zsr_feeder_model

/* File: bench/zsr_sva.sv */
// checker: port-level assertions for the zero-sequence recloser
`timescale 1ns/1ps
module zsr_sva (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // recloser pins
    input wire logic ENABLE_I,
    input wire logic OVERVOLTAGE_BLOCKED_IN_I,
    input wire logic RECLOSER_BLOCKED_O,
    input wire logic RECLOSER_ACTIVE_O,
    input wire logic BREAKER_CLOSE_CMD_O,
    input wire logic OVERVOLTAGE_BLOCK_OUT_O,
    // read channel
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic RVALID_O
);
    // ========================================
    // properties
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    property p_no_close; RECLOSER_BLOCKED_O |-> !BREAKER_CLOSE_CMD_O; endproperty
    a_no_close: assert property (p_no_close) else $error("close while blocked");
    property p_en_low; (!ENABLE_I)[*6] |-> RECLOSER_BLOCKED_O; endproperty
    a_en_low: assert property (p_en_low) else $error("enable low, not blocked");
    property p_excl; RECLOSER_BLOCKED_O |-> !RECLOSER_ACTIVE_O && !OVERVOLTAGE_BLOCK_OUT_O;
    endproperty
    a_excl: assert property (p_excl) else $error("blocked with active");
    property p_close_ctx; BREAKER_CLOSE_CMD_O |-> RECLOSER_ACTIVE_O && OVERVOLTAGE_BLOCK_OUT_O;
    endproperty
    a_close_ctx: assert property (p_close_ctx) else $error("close outside active");
    property p_after; BREAKER_CLOSE_CMD_O |=> OVERVOLTAGE_BLOCK_OUT_O; endproperty
    a_after: assert property (p_after) else $error("block lost after close");
    property p_ovb; OVERVOLTAGE_BLOCK_OUT_O |-> RECLOSER_ACTIVE_O; endproperty
    a_ovb: assert property (p_ovb) else $error("block without active");
    // the input passes two sync flops and the state before the output moves
    property p_rel; $fell(OVERVOLTAGE_BLOCK_OUT_O) && !RECLOSER_BLOCKED_O |->
        !$past(OVERVOLTAGE_BLOCKED_IN_I, 3) || !$past(OVERVOLTAGE_BLOCKED_IN_I, 4) ||
        !$past(OVERVOLTAGE_BLOCKED_IN_I, 5); endproperty
    a_rel: assert property (p_rel) else $error("block released early");
    property p_rd; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
endmodule  // zsr_sva

bind zero_seq_recloser zsr_sva u_sva (.CORE_CLK_I, .RSTN_I, .ENABLE_I,
    .OVERVOLTAGE_BLOCKED_IN_I, .RECLOSER_BLOCKED_O, .RECLOSER_ACTIVE_O, .BREAKER_CLOSE_CMD_O,
    .OVERVOLTAGE_BLOCK_OUT_O, .ARVALID_I, .ARREADY_O, .RVALID_O);

/* File: core/zero_seq_recloser.sv */
// zero-sequence recloser control with AXI4-Lite registers, event flags and record log
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module zero_seq_recloser
    import zsr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = DELAY_STEP_CYCLES,
    parameter int unsigned MS_CYCLES = STAMP_STEP_CYCLES
) (
    // clock, reset, clock enable
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // recloser pins
    input wire logic ENABLE_I,
    input wire logic OVERVOLTAGE_TRIP_IN_I,
    input wire logic OVERVOLTAGE_BLOCKED_IN_I,
    output logic RECLOSER_BLOCKED_O,
    output logic RECLOSER_ACTIVE_O,
    output logic BREAKER_CLOSE_CMD_O,
    output logic OVERVOLTAGE_BLOCK_OUT_O,
    output logic IRQ_O,
    // AXI4-Lite write
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [7:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    // AXI4-Lite read
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [7:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O
);
    typedef struct packed {
        logic [1:0] en_s;
        logic [1:0] trip_s;
        logic [1:0] blk_s;
        cond_t fsm;
        logic [19:0] pre_tick;
        logic [DELAY_W-1:0] cnt;
        logic [19:0] pre_ms;
        logic [31:0] ms;
        logic [4:0] flags;
        logic [4:0] prev;
        logic been_active;
        logic [EVT_W-1:0] evt_stat;
        logic [EVT_W-1:0] evt_en;
        logic [EVT_W-1:0] evt_sel;
        logic force_en;
        logic [2:0] force_sel;
        logic [2:0] group;
        logic [GROUPS-1:0][DELAY_W-1:0] delay;
        logic [3:0] log_head;
        logic [3:0] log_cnt;
        logic [3:0] log_sel;
        logic irq;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t st, next_st;
    logic [REC_W-1:0] log_rdata;
    logic [4:0] ev_on;
    logic [4:0] ev_off;
    logic [EVT_W-1:0] ev_all;
    logic log_we;
    logic [REC_W-1:0] log_wdata;

    // =========================================================================
    // events and log write
    assign ev_on = st.flags & ~st.prev;
    assign ev_off = st.prev & ~st.flags;
    generate
        for (genvar i = 0; i < 5; i++) begin : g_evt
            assign ev_all[2*i] = ev_on[i];
            assign ev_all[2*i+1] = ev_off[i];
        end
    endgenerate
    assign log_we = ev_on[FLAG_CLOSE] | ev_on[FLAG_BLOCKED];
    // record: timestamp, been active, time before close, group, event (1 = close)
    assign log_wdata = {st.ms, st.been_active, st.cnt, st.group, ev_on[FLAG_CLOSE]};

    zsr_log_mem u_log_mem (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .ce_i(CE_I),
        .we_i(log_we),
        .waddr_i(st.log_head),
        .wdata_i(log_wdata),
        .raddr_i(st.log_sel),
        .rdata_o(log_rdata)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [4:0] flags_of(input cond_t c);
        logic [4:0] f;
        f = '0;
        f[FLAG_REQUEST] = (c == COND_REQUESTED);
        f[FLAG_BLOCKED] = (c == COND_BLOCKED);
        f[FLAG_ACTIVE] = (c == COND_REQUESTED) || (c == COND_ACTIVE) ||
            (c == COND_CLOSE_CMD) || (c == COND_CLOSED_BLK);
        f[FLAG_CLOSE] = (c == COND_CLOSE_CMD);
        f[FLAG_OV_BLOCK] = (c == COND_ACTIVE) || (c == COND_CLOSE_CMD) ||
            (c == COND_CLOSED_BLK);
        return f;
    endfunction

    always_comb begin
        logic en;
        logic trip;
        logic blk;
        logic [31:0] wr;
        logic [31:0] cur;
        logic [EVT_W-1:0] clr;
        cond_t shown;
        en = st.en_s[1];
        trip = st.trip_s[1];
        blk = st.blk_s[1];
        wr = '0;
        cur = '0;
        clr = '0;
        shown = COND_NORMAL;
        next_st = st;
        // pins pass two flops before use
        next_st.en_s = {st.en_s[0], ENABLE_I};
        next_st.trip_s = {st.trip_s[0], OVERVOLTAGE_TRIP_IN_I};
        next_st.blk_s = {st.blk_s[0], OVERVOLTAGE_BLOCKED_IN_I};

        // =====================================================================
        // millisecond timestamp
        if (st.pre_ms >= 20'(MS_CYCLES - 1)) begin
            next_st.pre_ms = '0;
            next_st.ms = st.ms + 32'h1;
        end else begin
            next_st.pre_ms = st.pre_ms + 20'h1;
        end

        // =====================================================================
        // sequence
        if (!en) begin
            next_st.fsm = COND_BLOCKED;
        end else begin
            case (st.fsm)
                COND_BLOCKED: next_st.fsm = COND_NORMAL;
                COND_NORMAL: begin
                    if (trip) begin
                        next_st.fsm = COND_REQUESTED;
                    end
                end
                COND_REQUESTED: begin
                    if (blk) begin
                        next_st.fsm = COND_ACTIVE;
                    end else if (!trip) begin
                        next_st.fsm = COND_NORMAL; // fault cleared by own trip
                    end
                end
                COND_ACTIVE: begin
                    if (!blk) begin
                        next_st.fsm = COND_REQUESTED;
                    end else if (st.cnt >= st.delay[st.group]) begin
                        next_st.fsm = COND_CLOSE_CMD;
                    end
                end
                COND_CLOSE_CMD: next_st.fsm = COND_CLOSED_BLK;
                COND_CLOSED_BLK: begin
                    // protection stays blocked by us until its indications drop
                    if (!trip && !blk) begin
                        next_st.fsm = COND_NORMAL;
                    end
                end
                default: next_st.fsm = COND_NORMAL;
            endcase
        end

        // delay runs in 5 ms steps, only while the protection reports blocked
        if (st.fsm == COND_ACTIVE && blk) begin
            if (st.pre_tick >= 20'(TICK_CYCLES - 1)) begin
                next_st.pre_tick = '0;
                next_st.cnt = st.cnt + 19'h1;
            end else begin
                next_st.pre_tick = st.pre_tick + 20'h1;
            end
        end else if (st.fsm != COND_CLOSE_CMD && st.fsm != COND_CLOSED_BLK) begin
            next_st.pre_tick = '0;
            next_st.cnt = '0;
        end

        // forcing overrides what the outputs show, the sequence keeps running
        shown = next_st.fsm;
        if (st.force_en) begin
            case (st.force_sel)
                FORCE_BLOCK: shown = COND_BLOCKED;
                FORCE_REQUESTED: shown = COND_REQUESTED;
                FORCE_CLOSE_CMD: shown = COND_CLOSE_CMD;
                FORCE_CLOSED_BLK: shown = COND_CLOSED_BLK;
                default: shown = next_st.fsm;
            endcase
        end
        next_st.flags = flags_of(shown);
        next_st.prev = st.flags;

        // =====================================================================
        // log ring and been-active tracking
        if (log_we) begin
            next_st.log_head = (st.log_head == LOG_LAST) ? 4'h0 : st.log_head + 4'h1;
            if (st.log_cnt != LOG_LAST + 4'h1) begin
                next_st.log_cnt = st.log_cnt + 4'h1;
            end
            next_st.been_active = 1'b0;
        end
        if (st.flags[FLAG_ACTIVE]) begin
            next_st.been_active = 1'b1;
        end

        // =====================================================================
        // write channel: address and data may arrive in either order
        if (AWVALID_I && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = AWADDR_I;
        end
        if (WVALID_I && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = WDATA_I;
            next_st.wstrb = WSTRB_I;
        end
        if (st.bvalid && BREADY_I) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            case (st.awaddr)
                CTRL_ADDR: begin
                    cur = {25'h0, st.group, st.force_sel, st.force_en};
                    wr = merge(cur, st.wdata, st.wstrb);
                    next_st.force_en = wr[CTRL_FORCE_EN_BIT];
                    next_st.force_sel = wr[CTRL_FORCE_LSB +: 3];
                    next_st.group = wr[CTRL_GROUP_LSB +: 3];
                end
                EVT_CLR_ADDR: begin
                    wr = merge(32'h0, st.wdata, st.wstrb);
                    clr = wr[EVT_W-1:0];
                end
                EVT_EN_ADDR: begin
                    wr = merge({22'h0, st.evt_en}, st.wdata, st.wstrb);
                    next_st.evt_en = wr[EVT_W-1:0];
                end
                EVT_SEL_ADDR: begin
                    wr = merge({22'h0, st.evt_sel}, st.wdata, st.wstrb);
                    next_st.evt_sel = wr[EVT_W-1:0];
                end
                LOG_SEL_ADDR: begin
                    wr = merge({28'h0, st.log_sel}, st.wdata, st.wstrb);
                    next_st.log_sel = wr[3:0];
                end
                COND_ADDR, EVT_STAT_ADDR, TIME_ADDR, LOG_INFO_ADDR, LOG_TS_ADDR,
                LOG_REC_ADDR: begin
                    next_st.bresp = RESP_OKAY;
                end
                default: begin
                    if (st.awaddr >= DELAY_BASE_ADDR && st.awaddr <= DELAY_LAST_ADDR &&
                        st.awaddr[1:0] == 2'h0) begin
                        cur = {13'h0, st.delay[st.awaddr[4:2]]};
                        wr = merge(cur, st.wdata, st.wstrb);
                        next_st.delay[st.awaddr[4:2]] = wr[DELAY_W-1:0];
                    end else begin
                        next_st.bresp = RESP_DECERR;
                    end
                end
            endcase
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // event flags: set wins over clear
        next_st.evt_stat = (st.evt_stat & ~clr) | (ev_all & st.evt_sel);
        next_st.irq = |(next_st.evt_stat & st.evt_en);

        // =====================================================================
        // read channel
        if (st.rvalid && RREADY_I) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (ARVALID_I && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = '0;
            case (ARADDR_I)
                CTRL_ADDR: next_st.rdata = {25'h0, st.group, st.force_sel, st.force_en};
                COND_ADDR: next_st.rdata = {24'h0, en, st.flags[FLAG_OV_BLOCK],
                    st.flags[FLAG_CLOSE], st.flags[FLAG_ACTIVE], st.flags[FLAG_BLOCKED],
                    shown};
                EVT_STAT_ADDR: next_st.rdata = {22'h0, st.evt_stat};
                EVT_CLR_ADDR: next_st.rdata = '0;
                EVT_EN_ADDR: next_st.rdata = {22'h0, st.evt_en};
                EVT_SEL_ADDR: next_st.rdata = {22'h0, st.evt_sel};
                TIME_ADDR: next_st.rdata = st.ms;
                LOG_INFO_ADDR: next_st.rdata = {24'h0, st.log_cnt, st.log_head};
                LOG_SEL_ADDR: next_st.rdata = {28'h0, st.log_sel};
                LOG_TS_ADDR: next_st.rdata = log_rdata[REC_W-1 -: 32];
                LOG_REC_ADDR: next_st.rdata = {8'h0, log_rdata[23:0]};
                default: begin
                    if (ARADDR_I >= DELAY_BASE_ADDR && ARADDR_I <= DELAY_LAST_ADDR &&
                        ARADDR_I[1:0] == 2'h0) begin
                        next_st.rdata = {13'h0, st.delay[ARADDR_I[4:2]]};
                    end else begin
                        next_st.rresp = RESP_DECERR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st <= '0;
            st.fsm <= COND_BLOCKED;
            st.flags <= 5'h02;
            st.prev <= 5'h02;
            st.evt_sel <= EVT_SEL_RESET;
            st.delay <= {GROUPS{DELAY_RESET}};
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else if (CE_I) begin
            st <= next_st;
        end
    end

    // =========================================================================
    // outputs straight from state flops
    assign RECLOSER_BLOCKED_O = st.flags[FLAG_BLOCKED];
    assign RECLOSER_ACTIVE_O = st.flags[FLAG_ACTIVE];
    assign BREAKER_CLOSE_CMD_O = st.flags[FLAG_CLOSE];
    assign OVERVOLTAGE_BLOCK_OUT_O = st.flags[FLAG_OV_BLOCK];
    assign IRQ_O = st.irq;
    assign AWREADY_O = st.awready;
    assign WREADY_O = st.wready;
    assign BVALID_O = st.bvalid;
    assign BRESP_O = st.bresp;
    assign ARREADY_O = st.arready;
    assign RVALID_O = st.rvalid;
    assign RDATA_O = st.rdata;
    assign RRESP_O = st.rresp;
endmodule // zero_seq_recloser

/* File: core/zsr_log_mem.sv */
// twelve-entry record store with registered read data
`timescale 1ns/1ps
module zsr_log_mem
    import zsr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // write side
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [REC_W-1:0] wdata_i,
    // read side
    input wire logic [3:0] raddr_i,
    output logic [REC_W-1:0] rdata_o
);
    typedef struct packed {
        logic [LOG_DEPTH-1:0][REC_W-1:0] mem;
        logic [REC_W-1:0] rdata;
    } mem_state_t;

    mem_state_t st, next_st;

    always_comb begin
        next_st = st;
        if (we_i && waddr_i <= LOG_LAST) begin
            next_st.mem[waddr_i] = wdata_i;
        end
        next_st.rdata = (raddr_i <= LOG_LAST) ? st.mem[raddr_i] : '0;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
endmodule // zsr_log_mem

/* File: core/zsr_pkg.sv */
// package: register map, field layout, reset values and timing for the zero-sequence recloser
package zsr_pkg;
    // =========================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DELAY_STEP_NS = 5_000_000;
    localparam int unsigned STAMP_STEP_NS = 1_000_000;
    localparam int unsigned DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned STAMP_STEP_CYCLES = STAMP_STEP_NS / CLK_PERIOD_NS;
    // =========================================================================
    // sizes
    localparam int unsigned GROUPS = 8;
    localparam int unsigned LOG_DEPTH = 12;
    localparam int unsigned DELAY_W = 19;
    localparam int unsigned EVT_W = 10;
    localparam int unsigned REC_W = 56;
    localparam logic [3:0] LOG_LAST = 4'hb;
    // =========================================================================
    // register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] COND_ADDR = 8'h04;
    localparam logic [7:0] EVT_STAT_ADDR = 8'h08;
    localparam logic [7:0] EVT_CLR_ADDR = 8'h0c;
    localparam logic [7:0] EVT_EN_ADDR = 8'h10;
    localparam logic [7:0] EVT_SEL_ADDR = 8'h14;
    localparam logic [7:0] TIME_ADDR = 8'h18;
    localparam logic [7:0] LOG_INFO_ADDR = 8'h1c;
    localparam logic [7:0] LOG_SEL_ADDR = 8'h20;
    localparam logic [7:0] LOG_TS_ADDR = 8'h24;
    localparam logic [7:0] LOG_REC_ADDR = 8'h28;
    localparam logic [7:0] DELAY_BASE_ADDR = 8'h40;
    localparam logic [7:0] DELAY_LAST_ADDR = 8'h5c;
    // =========================================================================
    // fields: CTRL[0] force enable, CTRL[3:1] forced status, CTRL[6:4] group
    localparam int unsigned CTRL_FORCE_EN_BIT = 0;
    localparam int unsigned CTRL_FORCE_LSB = 1;
    localparam int unsigned CTRL_GROUP_LSB = 4;
    // event flag order, ON at bit 2*i, OFF at bit 2*i+1
    localparam int unsigned FLAG_REQUEST = 0;
    localparam int unsigned FLAG_BLOCKED = 1;
    localparam int unsigned FLAG_ACTIVE = 2;
    localparam int unsigned FLAG_CLOSE = 3;
    localparam int unsigned FLAG_OV_BLOCK = 4;
    // =========================================================================
    // reset values and response codes
    localparam logic [EVT_W-1:0] EVT_SEL_RESET = 10'h3ff;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 19'h00000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_REQUESTED = 3'h1,
        COND_BLOCKED = 3'h2,
        COND_ACTIVE = 3'h3,
        COND_CLOSE_CMD = 3'h4,
        COND_CLOSED_BLK = 3'h5
    } cond_t;

    typedef enum logic [2:0] {
        FORCE_NORMAL = 3'h0,
        FORCE_BLOCK = 3'h1,
        FORCE_REQUESTED = 3'h2,
        FORCE_CLOSE_CMD = 3'h3,
        FORCE_CLOSED_BLK = 3'h4
    } force_t;
endpackage
